// ### verilog/scpc_pkg.sv
package scpc_pkg;
  // Power states of the core clock controller, one-hot
  typedef enum logic [2:0]
  {
    SCPC_RUN   = 3'h1,  // Core clocks running
    SCPC_ACK   = 3'h2,  // Issuing halt acknowledge
    SCPC_HALT  = 3'h4   // Core clocks gated
  } scpc_state_t;

  localparam logic [1:0] SCPC_SYNC_RST   = 2'h3;  // Synchroniser idles deasserted (active low)
  localparam logic [2:0] SCPC_ACK_CYCLES = 3'h2;  // Hold count loaded on entry; an untaken request stands three cycles
  localparam logic [2:0] SCPC_ACK_ZERO   = 3'h0;  // Counter empty value
  localparam logic [1:0] SCPC_SYNC_STAGE = 2'h2;  // Depth of request synchroniser
endpackage

// ### verilog/scpc_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser for an asynchronous active-low level
module scpc_sync
  import scpc_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic async_n,
  output logic      sync_n
);
  logic [SCPC_SYNC_STAGE-1:0] stage_ff;  // Stage 0 feeds only stage 1

  // Shift the level through two flops
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      stage_ff <= SCPC_SYNC_RST;
    else if (clk_en)
      stage_ff <= {stage_ff[0], async_n};
  end

  assign sync_n = stage_ff[1];
endmodule // scpc_sync

// ### verilog/scpc_top.sv
`timescale 1ns/100ps
// Behaviour
// - Strap held at reset release tristates outputs
// - Stop request enters clock-halt state
// - Issue halt acknowledge on entry
// - Gate core clocks, keep bus and interrupt
// - Keep snooping and interrupt service while halted
// - Release restarts clocks and execution
// - External bus clock never gated
// - Stop request treated as asynchronous
// - Test clock alone clocks test port
// - Test data in shifts serially inward
// - Test data out shifts serially outward
module scpc_top
  import scpc_pkg::*;
(
  input  wire logic mclk,              // Core reference clock
  input  wire logic reset,             // Asynchronous reset, active high
  input  wire logic clk_en,            // Freezes all state but the test port when low
  input  wire logic stop_clock_req_n,  // Asynchronous stop request, active low
  input  wire logic sys_mgmt_irq_n,    // Strap sampled at reset release, active low
  input  wire logic ack_taken,         // Bus unit took the acknowledge transaction
  input  wire logic tck,               // Test port clock
  input  wire logic tdi,               // Serial test data in
  output logic      halt_ack_req,      // Request for halt acknowledge bus cycle
  output logic      core_clk_en,       // Core unit clock gate enable
  output logic      bus_clk_en,        // Bus interface unit clock enable
  output logic      lic_clk_en,        // Local interrupt controller clock enable
  output logic      snoop_en,          // Bus snooping permitted
  output logic      irq_service_en,    // Interrupt servicing permitted
  output logic      halted,            // In clock-halt state
  output logic      outputs_tristate,  // All outputs float
  output logic      tdo                // Serial test data out
);
  // Power state control
  logic        stop_sync_n;        // Synchronised stop request, active low
  scpc_state_t state_ff;           // Controller state
  scpc_state_t nxt_state;          // Next state
  logic        enter_ack;          // Run to acknowledge on this edge
  logic        ack_done;           // Acknowledge taken or hold time spent
  logic [2:0]  ack_cnt_ff;         // Acknowledge hold counter
  // Output registers
  logic        halt_ack_ff;        // Acknowledge request stage
  logic        core_clk_en_ff;     // Core unit clock gate stage
  logic        bus_clk_en_ff;      // Bus unit clock stage
  logic        lic_clk_en_ff;      // Interrupt controller clock stage
  logic        snoop_en_ff;        // Snoop permission stage
  logic        irq_service_en_ff;  // Interrupt service permission stage
  logic        halted_ff;          // Halt status stage
  // Strap and test port
  logic        rst_seen_ff;        // First enabled cycle after reset done
  logic        tristate_ff;        // Captured strap
  logic        tdo_ff;             // Test output stage

  // Request crosses into the core domain before any decision
  // Two stages settle a level that may change at any moment
  scpc_sync u_sync
  (
    .mclk    (mclk),
    .reset   (reset),
    .clk_en  (clk_en),
    .async_n (stop_clock_req_n),
    .sync_n  (stop_sync_n)
  );

  // Acknowledge phase ends on acceptance or when hold time runs out
  assign ack_done = ack_taken || (ack_cnt_ff == SCPC_ACK_ZERO);

  // Run to acknowledge on this edge; loads the hold counter
  assign enter_ack = (state_ff == SCPC_RUN) && !stop_sync_n;

  // Next state selection
  // Run, then acknowledge, then halt, then run again
  // Release only looked at in halt, so a short stop request
  // still completes the full acknowledge handshake
  always_comb
  begin
    nxt_state = state_ff;                                  // Hold by default
    case (state_ff)
      SCPC_RUN:                                            // Clocks running
        if (!stop_sync_n)
          nxt_state = SCPC_ACK;
      SCPC_ACK:                                            // Waiting on bus
        if (ack_done)
          nxt_state = SCPC_HALT;
      SCPC_HALT:                                           // Clocks gated
        if (stop_sync_n)
          nxt_state = SCPC_RUN;
      default:                                             // Illegal code recovers
        nxt_state = SCPC_RUN;
    endcase
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      state_ff <= SCPC_RUN;                                // Out of reset running
    else if (clk_en)
      state_ff <= nxt_state;
  end

  // Acknowledge request, raised on entry and dropped on leaving
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      halt_ack_ff <= 1'b0;
    else if (clk_en)
    begin
      if (enter_ack)
        halt_ack_ff <= 1'b1;
      else if (nxt_state != SCPC_ACK)
        halt_ack_ff <= 1'b0;                               // Taken or timed out
    end
  end

  // Hold counter bounds the wait for a slow bus agent
  // Two counts after load give three cycles in acknowledge
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      ack_cnt_ff <= SCPC_ACK_ZERO;
    else if (clk_en)
    begin
      if (enter_ack)
        ack_cnt_ff <= SCPC_ACK_CYCLES;                     // Load full hold time
      else if (state_ff == SCPC_ACK && !ack_done)
        ack_cnt_ff <= ack_cnt_ff - 3'h1;                   // Count down while waiting
    end
  end

  // Core unit clock gate, closed only in the halt state
  // Decoded from next state so gate and status move together
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      core_clk_en_ff <= 1'b1;                              // Core runs out of reset
    else if (clk_en)
      core_clk_en_ff <= (nxt_state != SCPC_HALT);
  end

  // Bus and interrupt controller clocks never stop
  // Kept as registers so every output leaves a flop
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      bus_clk_en_ff <= 1'b1;
      lic_clk_en_ff <= 1'b1;
    end
    else if (clk_en)
    begin
      bus_clk_en_ff <= 1'b1;
      lic_clk_en_ff <= 1'b1;
    end
  end

  // Snooping and interrupt service carry on through the halt
  // Both live in units whose clocks are never gated
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      snoop_en_ff       <= 1'b1;
      irq_service_en_ff <= 1'b1;
    end
    else if (clk_en)
    begin
      snoop_en_ff       <= 1'b1;
      irq_service_en_ff <= 1'b1;
    end
  end

  // Halt status, set on the same edge the core clock gate closes
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      halted_ff <= 1'b0;
    else if (clk_en)
      halted_ff <= (nxt_state == SCPC_HALT);
  end

  // Strap capture on the first enabled edge after release
  // Later changes of the strap pin are ignored until next reset
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      rst_seen_ff <= 1'b0;
      tristate_ff <= 1'b0;
    end
    else if (clk_en && !rst_seen_ff)
    begin
      rst_seen_ff <= 1'b1;                                 // Capture once
      tristate_ff <= !sys_mgmt_irq_n;
    end
  end

  // Test port path, clocked only by tck; a one-stage bypass
  // Clock enable does not reach it, as it belongs to the core clock
  always_ff @(negedge tck or posedge reset)
  begin
    if (reset)
      tdo_ff <= 1'b0;
    else
      tdo_ff <= tdi;
  end

  // Power control outputs, straight from their registers
  assign halt_ack_req     = halt_ack_ff;
  assign core_clk_en      = core_clk_en_ff;
  assign bus_clk_en       = bus_clk_en_ff;
  assign lic_clk_en       = lic_clk_en_ff;
  assign snoop_en         = snoop_en_ff;
  assign irq_service_en   = irq_service_en_ff;
  assign halted           = halted_ff;

  // Strap and test port outputs
  assign outputs_tristate = tristate_ff;
  assign tdo              = tdo_ff;
endmodule // scpc_top

// ### test/scpc_chk_sva.sv
`timescale 1ns/100ps
module scpc_chk
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic stop_clock_req_n,
  input wire logic ack_taken,
  input wire logic halt_ack_req,
  input wire logic core_clk_en,
  input wire logic bus_clk_en,
  input wire logic lic_clk_en,
  input wire logic snoop_en,
  input wire logic irq_service_en,
  input wire logic halted
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_gate; halted |-> !core_clk_en; endproperty
  a_gate: assert property (p_gate) else $error("core clock on in halt");
  property p_keep; bus_clk_en && lic_clk_en; endproperty
  a_keep: assert property (p_keep) else $error("bus clock gated");
  property p_snp; snoop_en && irq_service_en; endproperty
  a_snp: assert property (p_snp) else $error("snoop stopped");
  property p_ent; (!stop_clock_req_n && clk_en) [*5] |-> halt_ack_req || halted; endproperty
  a_ent: assert property (p_ent) else $error("no halt entry");
  property p_ack; $rose(halt_ack_req) |-> ##[1:3] halted; endproperty
  a_ack: assert property (p_ack) else $error("ack too long");
  property p_sync; $rose(halt_ack_req) |-> !$past(stop_clock_req_n, 3); endproperty
  a_sync: assert property (p_sync) else $error("ack too early");
  property p_rel; (stop_clock_req_n && clk_en) [*6] |-> !halted; endproperty
  a_rel: assert property (p_rel) else $error("no resume");
  property p_cke; $fell(halted) |-> core_clk_en && !halt_ack_req; endproperty
  a_cke: assert property (p_cke) else $error("clock off on resume");
  property p_frz; !clk_en |=> $stable(halted) && $stable(halt_ack_req) && $stable(core_clk_en); endproperty
  a_frz: assert property (p_frz) else $error("state moved while frozen");
  // Main scenarios reached
  c_frz: cover property (!clk_en && halted);
  c_ack: cover property (halt_ack_req && ack_taken);
  c_to: cover property (halt_ack_req [*3]);
  c_rel: cover property ($fell(halted));
endmodule // scpc_chk

// ### test/scpc_chipset.sv
`timescale 1ns/100ps
module scpc_chipset
(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic halt_ack_req,
  input  wire logic slow,
  output logic      ack_taken
);
  // Bus takes acknowledge at once, never when slow
  always @(negedge mclk or posedge reset)
    ack_taken <= !reset && halt_ack_req && !slow;
endmodule // scpc_chipset

// ### test/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic mclk = 0, reset = 1, clk_en = 1, stop_clock_req_n = 1, sys_mgmt_irq_n = 0, tck = 0, tdi = 0, slow = 0;
  logic ack_taken, halt_ack_req, core_clk_en, bus_clk_en, lic_clk_en, snoop_en, irq_service_en, halted;
  logic outputs_tristate, tdo;
  int err_count = 0, total_checks = 0, cyc = 0;
  scpc_top u_scpc_top(.*);
  scpc_chipset u_scpc_chipset(.*);
  initial forever #5 mclk = ~mclk;
  // Hang guard
  always @(posedge mclk) if (++cyc == 3000) begin err_count++; close_out; end
  task automatic chk(string n, logic e, logic s);
    total_checks++;
    if (s !== e) begin err_count++; $display("MISMATCH %s exp %b got %b", n, e, s); end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Reset with strap level s
  task automatic t_strap(logic s);
    @(negedge mclk) reset = 1;
    sys_mgmt_irq_n = s;
    repeat (12) @(negedge mclk);
    reset = 0;
    repeat (2) @(negedge mclk);
    chk("tristate", !s, outputs_tristate);
    sys_mgmt_irq_n = 1;
    $display("strap test done");
  endtask
  // Halt entry and release, prompt or timed out ack
  task automatic t_stop(logic sl);
    slow = sl;
    @(negedge mclk) stop_clock_req_n = 0;
    repeat (2) @(negedge mclk);
    chk("ack early", 0, halt_ack_req);
    @(negedge mclk);
    chk("ack", 1, halt_ack_req);
    if (sl)
    begin
      repeat (2) @(negedge mclk);
      chk("ack held", 1, halt_ack_req);
      chk("halt early", 0, halted);
    end
    @(negedge mclk);
    chk("halted", 1, halted);
    chk("ack drop", 0, halt_ack_req);
    chk("core", 0, core_clk_en);
    chk("keep", 1, bus_clk_en & lic_clk_en & snoop_en & irq_service_en);
    stop_clock_req_n = 1;
    repeat (2) @(negedge mclk);
    chk("still halted", 1, halted);
    @(negedge mclk);
    chk("resume", 1, core_clk_en & !halted);
    $display("stop test done");
  endtask
  // Clock enable low freezes entry and release
  task automatic t_freeze;
    slow = 0;
    @(negedge mclk) clk_en = 0;
    stop_clock_req_n = 0;
    repeat (5) @(negedge mclk);
    chk("frozen ack", 0, halt_ack_req);
    chk("frozen halt", 0, halted);
    clk_en = 1;
    repeat (3) @(negedge mclk);
    chk("thawed ack", 1, halt_ack_req);
    @(negedge mclk);
    chk("thawed halt", 1, halted);
    clk_en = 0;
    stop_clock_req_n = 1;
    repeat (5) @(negedge mclk);
    chk("frozen gate", 0, core_clk_en);
    clk_en = 1;
    repeat (3) @(negedge mclk);
    chk("thawed resume", 1, core_clk_en & !halted);
    $display("freeze test done");
  endtask
  // Bypass stage on test port
  task automatic t_tap;
    for (int i = 0; i < 4; i++)
    begin
      tdi = i[0];
      #3 tck = 1;
      #1 chk("tdo hold", (i > 0) && !i[0], tdo);
      #2 tck = 0;
      #1 chk("tdo", i[0], tdo);
    end
    $display("tap test done");
  endtask
  initial
  begin
    t_strap(0);
    t_strap(1);
    t_stop(0);
    t_stop(1);
    t_freeze;
    t_tap;
    close_out;
  end
endmodule // testbench
bind scpc_top scpc_chk u_scpc_chk(.*);
